// [hdl/lpw_ctrl.sv]
// Low-power mode and wake controller top
// Operation
// - Deep power-down: all off, eight pins wake
// - Five retention registers survive deep power-down
// - Lock bit refuses deep power-down entry
// - Per-mode oscillator, flash, peripheral power states
// - Wake buffers wake only from deep power-down
// - Sleep wakes on any enabled interrupt
// - Pin irq needs controller and pin enable
// - Brownout irq needs all enables, detector powered
// - Brownout reset needs enable, detector powered
// - Watchdog reset needs running, enable, oscillator
// - Wake pin needs its enable bit
// - Power-up runs from free running oscillator
// - Sleep stops core clock, peripherals run
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module lpw_ctrl
  import lpw_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Core
  input wire logic wfi_i,
  input wire logic [LPW_NUM_PIN_IRQ+LPW_NUM_PERIPH-1:0] nested_interrupt_controller_enable_i,
  input wire logic any_irq_i,
  // Wake sources
  input wire lpw_wake_t wake_i,
  input wire logic [LPW_NUM_WPIN-1:0] wake_pin_b_i,
  // Outputs
  output lpw_power_t power_o,
  output logic wake_reset_o,
  output logic clk_sel_osc_o,
  output logic irq_o
);
  typedef struct packed {
    lpw_state_t state;
    logic [2:0] mode;
    logic [LPW_NUM_PIN_IRQ-1:0] pin_wake;
    logic [LPW_NUM_PERIPH-1:0] periph_wake;
    logic [1:0] brownout;
    logic [1:0] sleep_cfg;
    logic [LPW_NUM_WPIN-1:0] wpin_en;
    logic lock;
    logic [LPW_IRQ_W-1:0] irq_stat;
    logic [LPW_IRQ_W-1:0] irq_mask;
    logic wake_reset;
    logic [31:0] rdata;
    logic rd_ret;
  } lpw_regs_t;

  lpw_regs_t q_r, q_nxt;
  logic [31:0] ret_rdata;
  logic ret_wr;

  function automatic logic in_low_dpd_less(lpw_state_t s);
    return (s == LPW_S_DEEP_SLEEP) || (s == LPW_S_POWER_DOWN);
  endfunction

  // Retention window decode; stray addresses above it must not alias into the bank
  function automatic logic ret_hit(logic [7:0] a);
    return (a >= LPW_ADDR_RET0) && (a < LPW_ADDR_RET0 + 8'(4 * LPW_NUM_RET)) && (a[1:0] == 2'b00);
  endfunction

  assign ret_wr = wr_i && ret_hit(addr_i) && (q_r.state == LPW_S_RUN);

  lpw_ret_mem #(
    .DEPTH(LPW_NUM_RET),
    .WIDTH(32)
  ) u_ret (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .wr_i(ret_wr),
    .addr_i(3'((addr_i - LPW_ADDR_RET0) >> 2)),
    .wdata_i(wdata_i),
    .rdata_o(ret_rdata)
  );

  logic pin_wake_hit, periph_wake_hit, bo_irq_wake, bo_rst_wake, wd_rst_wake, dpd_pin_wake;

  always_comb begin
    pin_wake_hit = |(wake_i.pin_irq & q_r.pin_wake & nested_interrupt_controller_enable_i[LPW_NUM_PIN_IRQ-1:0]);
    bo_irq_wake = wake_i.periph_irq[LPW_PW_BROWNOUT] && q_r.periph_wake[LPW_PW_BROWNOUT]
      && nested_interrupt_controller_enable_i[LPW_NUM_PIN_IRQ+LPW_PW_BROWNOUT] && q_r.brownout[LPW_BO_IRQ_EN]
      && q_r.sleep_cfg[LPW_SC_BROWNOUT_ON];
    // Other peripheral irqs, armed by software beforehand
    periph_wake_hit = |(wake_i.periph_irq & q_r.periph_wake
      & nested_interrupt_controller_enable_i[LPW_NUM_PIN_IRQ+LPW_NUM_PERIPH-1:LPW_NUM_PIN_IRQ]
      & ~(LPW_NUM_PERIPH'(1) << LPW_PW_BROWNOUT));
    bo_rst_wake = wake_i.brownout_rst && q_r.brownout[LPW_BO_RST_EN] && q_r.sleep_cfg[LPW_SC_BROWNOUT_ON];
    wd_rst_wake = wake_i.watchdog_rst && wake_i.watchdog_running && wake_i.watchdog_rst_en
      && q_r.sleep_cfg[LPW_SC_LPOSC_ON];
    dpd_pin_wake = |(~wake_pin_b_i & q_r.wpin_en);
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.wake_reset = 1'b0;
    q_nxt.rd_ret = rd_i && ret_hit(addr_i);
    q_nxt.rdata = LPW_RST_ZERO;
    // Register writes only while running
    if (wr_i && (q_r.state == LPW_S_RUN)) begin
      case (addr_i)
        LPW_ADDR_PWR_CTRL: q_nxt.mode = wdata_i[2:0];
        LPW_ADDR_PIN_WAKE: q_nxt.pin_wake = wdata_i[LPW_NUM_PIN_IRQ-1:0];
        LPW_ADDR_PERIPH_WAKE: q_nxt.periph_wake = wdata_i[LPW_NUM_PERIPH-1:0];
        LPW_ADDR_BROWNOUT: q_nxt.brownout = wdata_i[1:0];
        LPW_ADDR_SLEEP_CFG: q_nxt.sleep_cfg = wdata_i[1:0];
        LPW_ADDR_WAKE_PIN_EN: q_nxt.wpin_en = wdata_i[LPW_NUM_WPIN-1:0];
        LPW_ADDR_LOCK: q_nxt.lock = q_r.lock | wdata_i[0];
        LPW_ADDR_IRQ_MASK: q_nxt.irq_mask = wdata_i[LPW_IRQ_W-1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        LPW_ADDR_PWR_CTRL: q_nxt.rdata = {29'h0, q_r.mode};
        LPW_ADDR_PIN_WAKE: q_nxt.rdata = 32'(q_r.pin_wake);
        LPW_ADDR_PERIPH_WAKE: q_nxt.rdata = 32'(q_r.periph_wake);
        LPW_ADDR_BROWNOUT: q_nxt.rdata = {30'h0, q_r.brownout};
        LPW_ADDR_SLEEP_CFG: q_nxt.rdata = {30'h0, q_r.sleep_cfg};
        LPW_ADDR_WAKE_PIN_EN: q_nxt.rdata = 32'(q_r.wpin_en);
        LPW_ADDR_LOCK: q_nxt.rdata = {31'h0, q_r.lock};
        LPW_ADDR_STATUS: q_nxt.rdata = {29'h0, q_r.state};
        LPW_ADDR_IRQ_STAT: q_nxt.rdata = 32'(q_r.irq_stat);
        LPW_ADDR_IRQ_MASK: q_nxt.rdata = 32'(q_r.irq_mask);
        default: ;
      endcase
      // Read clears status; a same-cycle set below still wins
      if (addr_i == LPW_ADDR_IRQ_STAT) begin
        q_nxt.irq_stat = '0;
      end
    end
    case (q_r.state)
      LPW_S_RUN: begin
        if (wfi_i) begin
          case (lpw_mode_t'(q_r.mode))
            LPW_M_SLEEP: q_nxt.state = LPW_S_SLEEP;
            LPW_M_DEEP_SLEEP: q_nxt.state = LPW_S_DEEP_SLEEP;
            LPW_M_POWER_DOWN: q_nxt.state = LPW_S_POWER_DOWN;
            LPW_M_DEEP_PD: begin
              if (q_r.lock) begin
                q_nxt.irq_stat[LPW_IRQ_LOCK_REFUSE] = 1'b1;
              end else begin
                q_nxt.state = LPW_S_DEEP_PD;
              end
            end
            default: q_nxt.state = LPW_S_SLEEP;
          endcase
        end
      end
      LPW_S_SLEEP: begin
        if (any_irq_i) begin
          q_nxt.state = LPW_S_RUN;
          q_nxt.irq_stat[LPW_IRQ_WAKE] = 1'b1;
        end
      end
      LPW_S_DEEP_SLEEP, LPW_S_POWER_DOWN: begin
        if (bo_rst_wake || wd_rst_wake) begin
          q_nxt.state = LPW_S_RUN;
          q_nxt.wake_reset = 1'b1;
        end else if (pin_wake_hit || bo_irq_wake || periph_wake_hit) begin
          q_nxt.state = LPW_S_RUN;
          q_nxt.irq_stat[LPW_IRQ_WAKE] = 1'b1;
        end
      end
      LPW_S_DEEP_PD: begin
        if (dpd_pin_wake) begin
          q_nxt.state = LPW_S_RUN;
          q_nxt.wake_reset = 1'b1;
          q_nxt.irq_stat[LPW_IRQ_DPD_WAKE] = 1'b1;
        end
      end
      default: q_nxt.state = LPW_S_RUN;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_r.state <= LPW_S_RUN;
      q_r.mode <= LPW_MODE_RST;
      q_r.pin_wake <= '0;
      q_r.periph_wake <= '0;
      q_r.brownout <= '0;
      q_r.sleep_cfg <= '0;
      q_r.wpin_en <= '0;
      q_r.lock <= 1'b0;
      q_r.irq_stat <= '0;
      q_r.irq_mask <= '0;
      q_r.wake_reset <= 1'b0;
      q_r.rdata <= LPW_RST_ZERO;
      q_r.rd_ret <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // per-mode power table; detector and slow oscillator set below for deep sleep and power-down
  function automatic lpw_power_t power_for(lpw_state_t s, logic [1:0] cfg);
    lpw_power_t p;
    p = '1;
    case (s)
      LPW_S_RUN: begin
        p.core_clk_en = 1'b1;
        p.osc_on = 1'b1;
        p.osc_out_en = 1'b1;
        p.flash_on = 1'b1;
        p.flash_standby = 1'b1;
        p.periph_on = 1'b1;
        p.analog_on = 1'b1;
        p.brownout_on = 1'b1;
        p.lposc_on = 1'b1;
        p.logic_unit_on = 1'b1;
        p.main_domain_on = 1'b1;
      end
      LPW_S_SLEEP: begin
        // core clock stopped, peripherals keep running
        p.core_clk_en = 1'b0;
        p.osc_on = 1'b1;
        p.osc_out_en = 1'b1;
        p.flash_on = 1'b1;
        p.flash_standby = 1'b1;
        p.periph_on = 1'b1;
        p.analog_on = 1'b1;
        p.brownout_on = 1'b1;
        p.lposc_on = 1'b1;
        p.logic_unit_on = 1'b0;
        p.main_domain_on = 1'b1;
      end
      LPW_S_DEEP_SLEEP: begin
        // Oscillator kept alive for a short wake, its output gated
        p.core_clk_en = 1'b0;
        p.osc_on = 1'b1;
        p.osc_out_en = 1'b0;
        p.flash_on = 1'b0;
        p.flash_standby = 1'b1;
        p.periph_on = 1'b0;
        p.analog_on = 1'b0;
        p.logic_unit_on = 1'b0;
        p.main_domain_on = 1'b1;
      end
      LPW_S_POWER_DOWN: begin
        p.core_clk_en = 1'b0;
        p.osc_on = 1'b0;
        p.osc_out_en = 1'b0;
        p.flash_on = 1'b0;
        p.flash_standby = 1'b0;
        p.periph_on = 1'b0;
        p.analog_on = 1'b0;
        p.logic_unit_on = 1'b0;
        p.main_domain_on = 1'b1;
      end
      LPW_S_DEEP_PD: begin
        // only the wake pin logic keeps power
        p.core_clk_en = 1'b0;
        p.osc_on = 1'b0;
        p.osc_out_en = 1'b0;
        p.flash_on = 1'b0;
        p.flash_standby = 1'b0;
        p.periph_on = 1'b0;
        p.analog_on = 1'b0;
        p.brownout_on = 1'b0;
        p.lposc_on = 1'b0;
        p.logic_unit_on = 1'b0;
        p.main_domain_on = 1'b0;
      end
      default: p = '1;
    endcase
    // Detector and slow oscillator follow the sleep configuration
    if (in_low_dpd_less(s)) begin
      p.brownout_on = cfg[LPW_SC_BROWNOUT_ON];
      p.lposc_on = cfg[LPW_SC_LPOSC_ON];
    end
    return p;
  endfunction

  assign power_o = power_for(q_r.state, q_r.sleep_cfg);

  assign clk_sel_osc_o = 1'b1;
  assign wake_reset_o = q_r.wake_reset;
  assign irq_o = |(q_r.irq_stat & q_r.irq_mask);
  assign rdata_o = q_r.rd_ret ? ret_rdata : q_r.rdata;
endmodule // lpw_ctrl

// [inc/lpw_pkg.sv]
// Package for the low-power mode and wake controller
package lpw_pkg;
  // Register byte addresses (4 * register index)
  localparam logic [7:0] LPW_ADDR_PWR_CTRL = 8'h00;
  localparam logic [7:0] LPW_ADDR_PIN_WAKE = 8'h04;
  localparam logic [7:0] LPW_ADDR_PERIPH_WAKE = 8'h08;
  localparam logic [7:0] LPW_ADDR_BROWNOUT = 8'h0C;
  localparam logic [7:0] LPW_ADDR_SLEEP_CFG = 8'h10;
  localparam logic [7:0] LPW_ADDR_WAKE_PIN_EN = 8'h14;
  localparam logic [7:0] LPW_ADDR_LOCK = 8'h18;
  localparam logic [7:0] LPW_ADDR_STATUS = 8'h1C;
  localparam logic [7:0] LPW_ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] LPW_ADDR_IRQ_MASK = 8'h24;
  localparam logic [7:0] LPW_ADDR_RET0 = 8'h40;
  localparam int LPW_NUM_RET = 5;
  localparam int LPW_NUM_WPIN = 8;
  localparam int LPW_NUM_PIN_IRQ = 8;
  localparam int LPW_NUM_PERIPH = 8;
  // Peripheral wake bit positions
  localparam int LPW_PW_BROWNOUT = 0;
  localparam int LPW_PW_WATCHDOG = 1;
  localparam int LPW_PW_WAKE_TIMER = 2;
  localparam int LPW_PW_SERIAL = 3;
  localparam int LPW_PW_TOUCH = 4;
  // Brownout control bits
  localparam int LPW_BO_RST_EN = 0;
  localparam int LPW_BO_IRQ_EN = 1;
  // Sleep power config bits
  localparam int LPW_SC_BROWNOUT_ON = 0;
  localparam int LPW_SC_LPOSC_ON = 1;
  // Reset values
  localparam logic [31:0] LPW_RST_ZERO = 32'h0000_0000;
  localparam logic [2:0] LPW_MODE_RST = 3'h0;
  // Low-power mode selection
  typedef enum logic [2:0] {
    LPW_M_SLEEP = 3'b000,
    LPW_M_DEEP_SLEEP = 3'b001,
    LPW_M_POWER_DOWN = 3'b010,
    LPW_M_DEEP_PD = 3'b011
  } lpw_mode_t;
  // Controller states
  typedef enum logic [2:0] {
    LPW_S_RUN = 3'b000,
    LPW_S_SLEEP = 3'b001,
    LPW_S_DEEP_SLEEP = 3'b010,
    LPW_S_POWER_DOWN = 3'b011,
    LPW_S_DEEP_PD = 3'b100
  } lpw_state_t;
  // Power domain enables
  typedef struct packed {
    logic core_clk_en;
    logic osc_on;
    logic osc_out_en;
    logic flash_on;
    logic flash_standby;
    logic periph_on;
    logic analog_on;
    logic brownout_on;
    logic lposc_on;
    logic logic_unit_on;
    logic main_domain_on;
  } lpw_power_t;
  // Wake-source inputs
  typedef struct packed {
    logic [LPW_NUM_PIN_IRQ-1:0] pin_irq;
    logic [LPW_NUM_PERIPH-1:0] periph_irq;
    logic brownout_rst;
    logic watchdog_rst;
    logic watchdog_running;
    logic watchdog_rst_en;
  } lpw_wake_t;
  // Interrupt status bits
  localparam int LPW_IRQ_WAKE = 0;
  localparam int LPW_IRQ_LOCK_REFUSE = 1;
  localparam int LPW_IRQ_DPD_WAKE = 2;
  localparam int LPW_IRQ_W = 3;
endpackage

// [hdl/lpw_ret_mem.sv]
// Retention register bank, kept alive across deep power-down
`timescale 1ns/1ps
module lpw_ret_mem
  import lpw_pkg::*;
#(
  parameter int DEPTH = LPW_NUM_RET,
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Access
  input wire logic wr_i,
  input wire logic [2:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= LPW_RST_ZERO[WIDTH-1:0];
      end
      rdata_o <= LPW_RST_ZERO[WIDTH-1:0];
    end else begin
      if (wr_i && (32'(addr_i) < DEPTH)) begin
        mem_r[addr_i] <= wdata_i;
      end
      rdata_o <= (32'(addr_i) < DEPTH) ? mem_r[addr_i] : LPW_RST_ZERO[WIDTH-1:0];
    end
  end
endmodule // lpw_ret_mem

// [tb/lpw_ctrl_checker.sv]
// Port-level assertions for the low-power mode and wake controller
`timescale 1ns/1ps
module lpw_ctrl_checker
  import lpw_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Watched ports
  input wire logic any_irq_i,
  input wire lpw_wake_t wake_i,
  input wire lpw_power_t power_o,
  input wire logic wake_reset_o,
  input wire logic clk_sel_osc_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_sleep;
    !power_o.core_clk_en && power_o.periph_on;
  endsequence
  sequence s_deep_sleep;
    !power_o.core_clk_en && !power_o.periph_on && power_o.osc_on;
  endsequence
  sequence s_power_down;
    !power_o.core_clk_en && power_o.main_domain_on && !power_o.osc_on;
  endsequence
  a_dpd_all_off: assert property (!power_o.main_domain_on |-> power_o == '0)
    else $error("domain powered in deep power-down");
  a_logic_unit_off: assert property (!power_o.core_clk_en |-> !power_o.logic_unit_on)
    else $error("logic unit on in low-power mode");
  a_deep_sleep_gate: assert property (s_deep_sleep |-> !power_o.osc_out_en && power_o.flash_standby
    && !power_o.analog_on) else $error("deep-sleep power state wrong");
  a_pd_flash_off: assert property (s_power_down |-> !power_o.flash_on && !power_o.analog_on)
    else $error("flash or analog on in power-down");
  a_sleep_irq_wake: assert property (s_sleep ##0 any_irq_i |=> power_o.core_clk_en)
    else $error("sleep not left on interrupt");
  a_no_false_wake: assert property (!power_o.core_clk_en && power_o.main_domain_on && !any_irq_i
    && wake_i == '0 |=> !power_o.core_clk_en) else $error("woke without a source");
  a_dpd_exit_reset: assert property ($rose(power_o.main_domain_on) |-> wake_reset_o)
    else $error("deep power-down exit without reset pulse");
  a_reset_pulse_one: assert property (wake_reset_o |=> !wake_reset_o)
    else $error("wake reset longer than one cycle");
  a_reset_wake_run: assert property (wake_reset_o |-> power_o.core_clk_en)
    else $error("wake reset without running core");
  a_osc_selected: assert property (clk_sel_osc_o)
    else $error("free running oscillator not selected");
endmodule // lpw_ctrl_checker

// [tb/lpw_core_model.sv]
// Core and wake-source model: issues wait-for-interrupt, pulls wake pins low
`timescale 1ns/1ps
module lpw_core_model
  import lpw_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Bench commands
  input wire logic sleep_req_i,
  input wire logic [LPW_NUM_WPIN-1:0] pin_pull_i,
  input wire lpw_wake_t src_i,
  // From the controller
  input wire logic lposc_on_i,
  // Towards the controller
  output logic wfi_o,
  output logic [LPW_NUM_WPIN-1:0] wake_pin_b_o,
  output lpw_wake_t wake_o
);
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wfi_o <= 1'h0;
    end else begin
      wfi_o <= sleep_req_i;
    end
  end
  assign wake_pin_b_o = ~pin_pull_i;
  // Sources clocked by the slow oscillator; serial slaves run from an outside clock
  localparam logic [LPW_NUM_PERIPH-1:0] LPOSC_SRCS = LPW_NUM_PERIPH'((1 << LPW_PW_WATCHDOG)
    | (1 << LPW_PW_WAKE_TIMER) | (1 << LPW_PW_TOUCH));
  // no event while their oscillator is off
  always_comb begin
    wake_o = src_i;
    if (!lposc_on_i) begin
      wake_o.periph_irq = src_i.periph_irq & ~LPOSC_SRCS;
    end
  end
endmodule // lpw_core_model

// [tb/lpw_ctrl_bench.sv]
// Self-checking bench for the low-power mode and wake controller
`timescale 1ns/1ps
module lpw_ctrl_bench
  import lpw_pkg::*;
;
  logic clock_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [31:0] rdata_o, rdv;
  logic [15:0] nested_interrupt_controller_enable_i = 16'h0;
  logic any_irq_i = 1'h0;
  logic sleep_req = 1'h0;
  logic [7:0] pin_pull = 8'h00;
  lpw_wake_t src = '0;
  lpw_wake_t wake_i;
  logic wfi_i, wake_reset_o, clk_sel_osc_o, irq_o;
  logic [7:0] wake_pin_b_i;
  lpw_power_t power_o;
  int bad_count = 0;
  int n_compared = 0;
  always #4 clock_i = ~clock_i;
  lpw_core_model i_core (.clock_i(clock_i), .rst_b_i(rst_b_i), .sleep_req_i(sleep_req), .pin_pull_i(pin_pull),
    .src_i(src), .lposc_on_i(power_o.lposc_on), .wfi_o(wfi_i), .wake_pin_b_o(wake_pin_b_i), .wake_o(wake_i));
  lpw_ctrl i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .wfi_i(wfi_i), .nested_interrupt_controller_enable_i(nested_interrupt_controller_enable_i), .any_irq_i(any_irq_i),
    .wake_i(wake_i), .wake_pin_b_i(wake_pin_b_i), .power_o(power_o), .wake_reset_o(wake_reset_o),
    .clk_sel_osc_o(clk_sel_osc_o), .irq_o(irq_o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic core(input logic e);
    chk(32'(power_o.core_clk_en), 32'(e));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1;
    rdv = rdata_o;
  endtask
  task automatic sleep_in(input lpw_mode_t m);
    wr(LPW_ADDR_PWR_CTRL, 32'(m));
    @(posedge clock_i);
    sleep_req <= 1'h1;
    @(posedge clock_i);
    sleep_req <= 1'h0;
    cyc(2);
  endtask
  task automatic t_sleep();
    rd(8'h30);
    chk(rdv, 32'h0);
    chk(32'(clk_sel_osc_o), 32'h1);
    wr(LPW_ADDR_IRQ_MASK, 32'h7);
    wr(LPW_ADDR_WAKE_PIN_EN, 32'hFF);
    sleep_in(LPW_M_SLEEP);
    chk(32'({power_o.core_clk_en, power_o.periph_on, power_o.logic_unit_on}), 32'h2);
    rd(LPW_ADDR_STATUS);
    chk(rdv, 32'(LPW_S_SLEEP));
    pin_pull <= 8'hFF;
    cyc(3);
    core(1'h0);
    pin_pull <= 8'h00;
    any_irq_i <= 1'h1;
    cyc(1);
    core(1'h1);
    any_irq_i <= 1'h0;
    chk(32'(irq_o), 32'h1);
    rd(LPW_ADDR_IRQ_STAT);
    chk(rdv, 32'h1);
    cyc(1);
    chk(32'(irq_o), 32'h0);
  endtask
  task automatic t_deep_sleep();
    wr(LPW_ADDR_PIN_WAKE, 32'h5);
    nested_interrupt_controller_enable_i <= 16'h0303;
    sleep_in(LPW_M_DEEP_SLEEP);
    chk(32'({power_o.osc_on, power_o.osc_out_en, power_o.flash_standby, power_o.periph_on,
      power_o.analog_on, power_o.logic_unit_on}), 32'h28);
    src.pin_irq <= 8'h06;
    cyc(3);
    core(1'h0);
    src.pin_irq <= 8'h01;
    cyc(1);
    core(1'h1);
    src <= '0;
  endtask
  task automatic t_power_down();
    wr(LPW_ADDR_PERIPH_WAKE, 32'h3);
    wr(LPW_ADDR_BROWNOUT, 32'h2);
    wr(LPW_ADDR_SLEEP_CFG, 32'h2);
    sleep_in(LPW_M_POWER_DOWN);
    chk(32'({power_o.osc_on, power_o.flash_on, power_o.periph_on, power_o.logic_unit_on}), 32'h0);
    src.periph_irq <= 8'h01;
    src.brownout_rst <= 1'h1;
    cyc(3);
    core(1'h0);
    src <= '{watchdog_rst: 1'h1, watchdog_running: 1'h1, watchdog_rst_en: 1'h1, default: '0};
    cyc(1);
    chk(32'({power_o.core_clk_en, wake_reset_o}), 32'h3);
    src <= '0;
    wr(LPW_ADDR_SLEEP_CFG, 32'h1);
    sleep_in(LPW_M_POWER_DOWN);
    src.periph_irq <= 8'h01;
    cyc(1);
    core(1'h1);
    src <= '0;
    wr(LPW_ADDR_BROWNOUT, 32'h1);
    sleep_in(LPW_M_DEEP_SLEEP);
    src.brownout_rst <= 1'h1;
    cyc(1);
    chk(32'({power_o.core_clk_en, wake_reset_o}), 32'h3);
    src <= '0;
  endtask
  task automatic t_dpd();
    for (int i = 0; i < LPW_NUM_RET; i++) begin
      wr(LPW_ADDR_RET0 + 8'(4 * i), 32'hA5A5_0000 + i);
    end
    // Stray write above the bank must not alias into it
    wr(8'h60, 32'hFFFF_FFFF);
    wr(LPW_ADDR_WAKE_PIN_EN, 32'h80);
    sleep_in(LPW_M_DEEP_PD);
    chk(32'(power_o), 32'h0);
    pin_pull <= 8'h08;
    cyc(3);
    core(1'h0);
    pin_pull <= 8'h80;
    cyc(1);
    chk(32'({power_o.core_clk_en, wake_reset_o}), 32'h3);
    pin_pull <= 8'h00;
    for (int i = 0; i < LPW_NUM_RET; i++) begin
      rd(LPW_ADDR_RET0 + 8'(4 * i));
      chk(rdv, 32'hA5A5_0000 + i);
    end
    rd(LPW_ADDR_IRQ_STAT);
    chk(rdv & 32'h4, 32'h4);
  endtask
  task automatic t_lock();
    wr(LPW_ADDR_LOCK, 32'h1);
    sleep_in(LPW_M_DEEP_PD);
    chk(32'({power_o.core_clk_en, power_o.main_domain_on}), 32'h3);
    rd(LPW_ADDR_IRQ_STAT);
    chk(rdv & 32'h2, 32'h2);
  endtask
  task automatic t_periph();
    // wake enables armed, watchdog left off the controller
    wr(LPW_ADDR_PERIPH_WAKE, 32'h1E);
    wr(LPW_ADDR_SLEEP_CFG, 32'h2);
    nested_interrupt_controller_enable_i <= 16'h1C00;
    sleep_in(LPW_M_POWER_DOWN);
    src.periph_irq <= 8'h02;
    cyc(3);
    core(1'h0);
    src.periph_irq <= 8'h04;
    cyc(1);
    core(1'h1);
    src <= '0;
    wr(LPW_ADDR_SLEEP_CFG, 32'h0);
    sleep_in(LPW_M_DEEP_SLEEP);
    src.periph_irq <= 8'h12;
    cyc(3);
    core(1'h0);
    src.periph_irq <= 8'h08;
    cyc(1);
    core(1'h1);
    src <= '0;
  endtask
  task automatic t_reset();
    rst_b_i <= 1'h0;
    cyc(2);
    chk(32'(power_o), 32'h7FF);
    rst_b_i <= 1'h1;
    rd(LPW_ADDR_LOCK);
    chk(rdv, 32'h0);
    rd(LPW_ADDR_RET0);
    chk(rdv, 32'h0);
  endtask
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    rst_b_i <= 1'h1;
    t_sleep();
    t_deep_sleep();
    t_power_down();
    t_periph();
    t_dpd();
    t_lock();
    t_reset();
    complete_run();
  end
endmodule // lpw_ctrl_bench
bind lpw_ctrl lpw_ctrl_checker i_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .any_irq_i(any_irq_i),
  .wake_i(wake_i), .power_o(power_o), .wake_reset_o(wake_reset_o), .clk_sel_osc_o(clk_sel_osc_o));
